/* design/afcm_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module afcm_ctrl
(
    input  wire logic                              hclk,
    input  wire logic                              hresetn,
    input  wire logic                              hsel,
    input  wire logic [31:0]                       haddr,
    input  wire logic [1:0]                        htrans,
    input  wire logic                              hwrite,
    input  wire logic [2:0]                        hsize,
    input  wire logic [31:0]                       hwdata,
    input  wire logic                              hready,
    output logic      [31:0]                       hrdata,
    output logic                                   hreadyout,
    output logic                                   hresp,
    input  wire logic signed [afcm_pkg::FREQ_W-1:0] est_offset_hz,
    input  wire logic                              est_valid,
    input  wire logic        [afcm_pkg::EBN0_W-1:0] ebn0,
    input  wire logic        [afcm_pkg::FREQ_W-1:0] native_tol_hz,
    input  wire logic                              enter_key,
    input  wire logic                              mode_item_sel,
    output logic signed      [afcm_pkg::FREQ_W-1:0] corr_hz,
    output logic             [1:0]                 eff_mode,
    output logic                                   override_active
);

    afcm_pkg::afcm_mode_t mode_r;
    afcm_pkg::afcm_mode_t mode_nxt;
    afcm_pkg::afcm_mode_t eff_m;
    logic                 ovr_en_r;
    logic [afcm_pkg::EBN0_W-1:0] thresh_r;
    logic signed [afcm_pkg::FREQ_W-1:0] corr_r;
    logic signed [afcm_pkg::FREQ_W-1:0] excess_w;

    logic        dph_r;
    logic        dph_wr_r;
    logic [7:0]  dph_addr_r;
    logic [31:0] rdata_r;
    logic        aph_take;
    logic        wr_ctrl;
    logic        wr_thresh;

    logic key_s1_r;
    logic key_s2_r;
    logic key_prev_r;
    logic key_press;
    logic tol_met;
    logic snr_ok;
    logic trk_ok_r;

    afcm_excess u_excess
    (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .offset_hz (est_offset_hz),
        .tol_hz    (native_tol_hz),
        .excess_r  (excess_w)
    );

    // Bus slave always ready, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_r;
    assign aph_take  = hsel && htrans[1] && hready;
    assign wr_ctrl   = dph_r && dph_wr_r && (dph_addr_r == afcm_pkg::ADDR_CTRL);
    assign wr_thresh = dph_r && dph_wr_r && (dph_addr_r == afcm_pkg::ADDR_THRESH);

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dph_r      <= 1'b0;
            dph_wr_r   <= 1'b0;
            dph_addr_r <= 8'h00;
        end
        else
        begin
            dph_r      <= aph_take;
            dph_wr_r   <= aph_take && hwrite;
            dph_addr_r <= aph_take ? {haddr[7:2], 2'b00} : dph_addr_r;
        end
    end

    // Read data registered in the address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rdata_r <= 32'h00000000;
        end
        else if (aph_take && !hwrite)
        begin
            if (haddr[7:0] == afcm_pkg::ADDR_CTRL)
            begin
                rdata_r <= {29'h0, ovr_en_r, 2'(mode_r)};
            end
            else if (haddr[7:0] == afcm_pkg::ADDR_THRESH)
            begin
                rdata_r <= {24'h0, thresh_r};
            end
            else if (haddr[7:0] == afcm_pkg::ADDR_STATUS)
            begin
                rdata_r <= {29'h0, override_active, 2'(eff_m)};
            end
            else if (haddr[7:0] == afcm_pkg::ADDR_CORR)
            begin
                rdata_r <= {{(32 - afcm_pkg::FREQ_W){corr_r[afcm_pkg::FREQ_W-1]}}, corr_r};
            end
            else
            begin
                rdata_r <= 32'h00000000;
            end
        end
    end

    // Enter key synchroniser and press detect
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            key_s1_r   <= 1'b0;
            key_s2_r   <= 1'b0;
            key_prev_r <= 1'b0;
        end
        else
        begin
            key_s1_r   <= enter_key;
            key_s2_r   <= key_s1_r;
            key_prev_r <= key_s2_r;
        end
    end

    assign key_press = key_s2_r && !key_prev_r && mode_item_sel;

    // User mode selection: bus write wins over a key press in the same cycle
    always_comb
    begin
        mode_nxt = mode_r;
        if (wr_ctrl)
        begin
            case (hwdata[afcm_pkg::CTRL_MODE_LSB +: 2])
                afcm_pkg::MODE_CODE_OFF:   mode_nxt = afcm_pkg::AFCM_OFF;
                afcm_pkg::MODE_CODE_TRACK: mode_nxt = afcm_pkg::AFCM_TRACK;
                afcm_pkg::MODE_CODE_HOLD:  mode_nxt = afcm_pkg::AFCM_HOLD;
                default:                   mode_nxt = mode_r;
            endcase
        end
        else if (key_press)
        begin
            case (mode_r)
                afcm_pkg::AFCM_OFF:   mode_nxt = afcm_pkg::AFCM_TRACK;
                afcm_pkg::AFCM_TRACK: mode_nxt = afcm_pkg::AFCM_HOLD;
                default:              mode_nxt = afcm_pkg::AFCM_OFF;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode_r <= afcm_pkg::AFCM_OFF;
        end
        else
        begin
            mode_r <= mode_nxt;
        end
    end

    // Override enable and threshold settings
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ovr_en_r <= afcm_pkg::RST_OVR_EN;
            thresh_r <= afcm_pkg::RST_THRESH;
        end
        else
        begin
            if (wr_ctrl)
            begin
                ovr_en_r <= hwdata[afcm_pkg::CTRL_OVR_BIT];
            end
            if (wr_thresh)
            begin
                thresh_r <= hwdata[afcm_pkg::EBN0_W-1:0];
            end
        end
    end

    // Effective mode after the automatic override
    assign tol_met = native_tol_hz >= afcm_pkg::OVR_TOL_HZ;
    assign override_active = ovr_en_r && tol_met;
    assign eff_m = override_active ? afcm_pkg::AFCM_OFF : mode_r;
    assign eff_mode = 2'(eff_m);
    assign snr_ok = ebn0 >= thresh_r;

    // Estimate qualifiers delayed to line up with the registered excess
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            trk_ok_r <= 1'b0;
        end
        else
        begin
            trk_ok_r <= est_valid && snr_ok;
        end
    end

    // Correction register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            corr_r <= afcm_pkg::RST_CORR;
        end
        else
        begin
            case (eff_m)
                afcm_pkg::AFCM_OFF:
                begin
                    corr_r <= afcm_pkg::RST_CORR;
                end
                afcm_pkg::AFCM_TRACK:
                begin
                    if (trk_ok_r)
                    begin
                        corr_r <= excess_w;
                    end
                end
                default:
                begin
                    corr_r <= corr_r;
                end
            endcase
        end
    end

    assign corr_hz = corr_r;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence s_key_edge;
        !key_s2_r ##1 key_s2_r;
    endsequence

    sequence s_hold_entry;
        eff_m != afcm_pkg::AFCM_HOLD ##1 eff_m == afcm_pkg::AFCM_HOLD;
    endsequence

    sequence s_est_good;
        (est_valid && snr_ok) ##1 eff_m == afcm_pkg::AFCM_TRACK;
    endsequence

    sequence s_est_bad;
        (!est_valid || !snr_ok) ##1 eff_m == afcm_pkg::AFCM_TRACK;
    endsequence

    mode_code_legal_a: assert property (eff_mode != 2'h3 &&
        (!(dph_r && !dph_wr_r && (dph_addr_r == afcm_pkg::ADDR_CTRL ||
                                   dph_addr_r == afcm_pkg::ADDR_STATUS)) ||
         rdata_r[1:0] != 2'h3))
        else $error("illegal mode code");

    off_zero_corr_a: assert property (eff_m == afcm_pkg::AFCM_OFF |=> corr_hz == '0)
        else $error("correction not zero in off mode");

    track_update_a: assert property (s_est_good |=> corr_hz == $past(excess_w))
        else $error("track mode did not apply estimate");

    track_suspend_a: assert property (s_est_bad |=> $stable(corr_hz))
        else $error("track mode updated below threshold");

    hold_freeze_a: assert property (s_hold_entry ##0 (eff_m == afcm_pkg::AFCM_HOLD)[*3]
        |-> corr_hz == $past(corr_hz, 2))
        else $error("hold mode correction moved");

    auto_override_a: assert property (ovr_en_r && native_tol_hz >= afcm_pkg::OVR_TOL_HZ
        |=> $past(eff_mode) == afcm_pkg::MODE_CODE_OFF && corr_hz == '0)
        else $error("override did not force off");

    override_prio_a: assert property (override_active && mode_r != afcm_pkg::AFCM_OFF
        |-> eff_m == afcm_pkg::AFCM_OFF)
        else $error("user mode beat override");

    no_override_a: assert property (!ovr_en_r |-> eff_m == mode_r && !override_active)
        else $error("override active while disabled");

    key_advance_a: assert property (s_key_edge ##0 (mode_item_sel && !wr_ctrl)
        |=> 2'(mode_r) == (($past(mode_r) == afcm_pkg::AFCM_HOLD) ?
            afcm_pkg::MODE_CODE_OFF : 2'($past(mode_r)) + 2'h1))
        else $error("key press did not advance mode");

    reset_zero_a: assert property (@(posedge hclk) disable iff (1'b0)
        $rose(hresetn) |-> corr_hz == '0)
        else $error("correction not zero after reset");

endmodule

`default_nettype wire

/* design/afcm_excess.sv */
`timescale 1ns/1ps
`default_nettype none

module afcm_excess
(
    input  wire logic                              hclk,
    input  wire logic                              hresetn,
    input  wire logic signed [afcm_pkg::FREQ_W-1:0] offset_hz,
    input  wire logic        [afcm_pkg::FREQ_W-1:0] tol_hz,
    output logic signed      [afcm_pkg::FREQ_W-1:0] excess_r
);

    logic signed [afcm_pkg::FREQ_W:0] off_x;
    logic signed [afcm_pkg::FREQ_W:0] tol_x;
    logic signed [afcm_pkg::FREQ_W:0] diff_x;
    logic signed [afcm_pkg::FREQ_W-1:0] excess_nxt;

    // Only the part of the offset beyond the loop's reach is kept
    always_comb
    begin
        off_x = {offset_hz[afcm_pkg::FREQ_W-1], offset_hz};
        tol_x = {1'b0, tol_hz};
        diff_x = '0;
        if (off_x > tol_x)
        begin
            diff_x = off_x - tol_x;
        end
        else if (off_x < -tol_x)
        begin
            diff_x = off_x + tol_x;
        end
        excess_nxt = diff_x[afcm_pkg::FREQ_W-1:0];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            excess_r <= afcm_pkg::RST_CORR;
        end
        else
        begin
            excess_r <= excess_nxt;
        end
    end

    in_band_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ($signed({offset_hz[afcm_pkg::FREQ_W-1], offset_hz}) <= $signed({1'b0, tol_hz}) &&
         $signed({offset_hz[afcm_pkg::FREQ_W-1], offset_hz}) >= -$signed({1'b0, tol_hz}))
        |=> excess_r == '0)
        else $error("excess not zero inside tolerance band");

endmodule

`default_nettype wire

/* design/afcm_pkg.sv */
package afcm_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_THRESH = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_CORR   = 8'h0c;

    // Field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_OVR_BIT  = 2;
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_OVR_BIT  = 2;

    // Widths
    localparam int FREQ_W = 24;
    localparam int EBN0_W = 8;

    // Mode field encodings
    localparam logic [1:0] MODE_CODE_OFF   = 2'h0;
    localparam logic [1:0] MODE_CODE_TRACK = 2'h1;
    localparam logic [1:0] MODE_CODE_HOLD  = 2'h2;

    // Values after reset
    localparam logic               RST_OVR_EN = 1'b1;
    localparam logic [EBN0_W-1:0]  RST_THRESH = 8'h28;
    localparam logic [FREQ_W-1:0]  RST_CORR   = 24'h000000;

    // Native tolerance at which the stage is forced off, in Hz
    localparam logic [FREQ_W-1:0]  OVR_TOL_HZ = 24'h00c350;

    typedef enum logic [1:0] {
        AFCM_OFF,
        AFCM_TRACK,
        AFCM_HOLD
    } afcm_mode_t;

endpackage

/* tb/afcm_link_model.sv */
`timescale 1ns/1ps
`default_nettype none

module afcm_link_model
(
    input  wire logic                          hclk,
    output logic signed [afcm_pkg::FREQ_W-1:0] est_offset_hz,
    output logic                               est_valid,
    output logic        [afcm_pkg::EBN0_W-1:0] ebn0,
    output logic        [afcm_pkg::FREQ_W-1:0] native_tol_hz,
    output logic                               enter_key,
    output logic                               mode_item_sel
);
    logic signed [afcm_pkg::FREQ_W-1:0] off_r;
    logic                               tgl_r;

    initial
    begin
        off_r = '0;
        tgl_r = 1'b0;
        est_valid = 1'b0;
        ebn0 = '0;
        native_tol_hz = '0;
        enter_key = 1'b0;
        mode_item_sel = 1'b0;
    end

    // Estimate is garbage while not valid
    always @(posedge hclk)
        tgl_r <= ~tgl_r;
    assign est_offset_hz = est_valid ? off_r : {12{tgl_r, ~tgl_r}};

    task set_link(input logic signed [23:0] off, input logic [23:0] tol,
                  input logic [7:0] snr, input logic vld);
        @(posedge hclk);
        off_r <= off;
        native_tol_hz <= tol;
        ebn0 <= snr;
        est_valid <= vld;
    endtask

    // One key press, menu item held over the whole press
    task press(input logic sel);
        @(posedge hclk);
        mode_item_sel <= sel;
        enter_key <= 1'b1;
        repeat (4) @(posedge hclk);
        enter_key <= 1'b0;
        repeat (4) @(posedge hclk);
        mode_item_sel <= 1'b0;
    endtask
endmodule

`default_nettype wire

/* tb/test_afc_mode_control.sv */
`timescale 1ns/1ps
`default_nettype none

module test_afc_mode_control;
    logic               hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic               est_valid, enter_key, mode_item_sel, override_active;
    logic        [1:0]  htrans, eff_mode;
    logic        [2:0]  hsize;
    logic        [31:0] haddr, hwdata, hrdata, rd;
    logic        [7:0]  ebn0;
    logic        [23:0] native_tol_hz;
    logic signed [23:0] est_offset_hz, corr_hz;
    logic signed [23:0] offs [4] = '{-24'sd30000, 24'sd15000, 24'sd20001, -24'sd50000};
    logic signed [23:0] exps [4] = '{-24'sd10000, 24'sd0, 24'sd1, -24'sd30000};
    int                 failures, checks, cyc;

    afcm_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .est_offset_hz(est_offset_hz), .est_valid(est_valid), .ebn0(ebn0),
        .native_tol_hz(native_tol_hz), .enter_key(enter_key),
        .mode_item_sel(mode_item_sel), .corr_hz(corr_hz), .eff_mode(eff_mode),
        .override_active(override_active));

    afcm_link_model model (.hclk(hclk), .est_offset_hz(est_offset_hz),
        .est_valid(est_valid), .ebn0(ebn0), .native_tol_hz(native_tol_hz),
        .enter_key(enter_key), .mode_item_sel(mode_item_sel));

    initial hclk = 1'b0;
    always #25 hclk = ~hclk;

    task end_sim;
        if (failures == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            failures++;
            end_sim;
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task chk_corr(input logic signed [23:0] exp);
        checks++;
        if (corr_hz !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, corr_hz, exp);
        end
    endtask

    task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask

    task st;
        repeat (3) @(posedge hclk);
        #1;
    endtask

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
        failures = 0;
        checks = 0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rdc(afcm_pkg::ADDR_CTRL, 32'h4);
        rdc(afcm_pkg::ADDR_THRESH, 32'h28);
        rdc(afcm_pkg::ADDR_CORR, 32'h0);
        rdc(8'h10, 32'h0);
        model.set_link(24'sd100000, 24'd20000, 8'h30, 1'b1);
        bus(afcm_pkg::ADDR_CTRL, 1'b1, 32'h2);
        st;
        chk_corr(24'sd0);
        bus(afcm_pkg::ADDR_CTRL, 1'b1, 32'h1);
        st;
        chk_corr(24'sd80000);
        for (int i = 0; i < 4; i++)
        begin
            model.set_link(offs[i], 24'd20000, 8'h28, 1'b1);
            st;
            chk_corr(exps[i]);
        end
        model.set_link(24'sd60000, 24'd20000, 8'h27, 1'b1);
        st;
        chk_corr(-24'sd30000);
        model.set_link(24'sd60000, 24'd20000, 8'h30, 1'b0);
        st;
        chk_corr(-24'sd30000);
        model.set_link(24'sd60000, 24'd20000, 8'h30, 1'b1);
        st;
        chk_corr(24'sd40000);
        bus(afcm_pkg::ADDR_CTRL, 1'b1, 32'h2);
        model.set_link(-24'sd90000, 24'd20000, 8'h30, 1'b1);
        st;
        chk_corr(24'sd40000);
        rdc(afcm_pkg::ADDR_STATUS, 32'h2);
        bus(afcm_pkg::ADDR_CORR, 1'b1, 32'h0);
        rdc(afcm_pkg::ADDR_CORR, 32'h9c40);
        bus(afcm_pkg::ADDR_CTRL, 1'b1, 32'h3);
        rdc(afcm_pkg::ADDR_CTRL, 32'h2);
        bus(afcm_pkg::ADDR_CTRL, 1'b1, 32'h0);
        st;
        chk_corr(24'sd0);
        model.set_link(-24'sd90000, 24'd50000, 8'h30, 1'b1);
        bus(afcm_pkg::ADDR_CTRL, 1'b1, 32'h5);
        st;
        rdc(afcm_pkg::ADDR_STATUS, 32'h4);
        chk({31'h0, override_active}, 32'h1);
        chk_corr(24'sd0);
        model.set_link(-24'sd90000, 24'd49999, 8'h30, 1'b1);
        st;
        rdc(afcm_pkg::ADDR_STATUS, 32'h1);
        chk_corr(-24'sd40001);
        model.set_link(-24'sd90000, 24'd50000, 8'h30, 1'b1);
        bus(afcm_pkg::ADDR_CTRL, 1'b1, 32'h1);
        st;
        rdc(afcm_pkg::ADDR_STATUS, 32'h1);
        chk({31'h0, override_active}, 32'h0);
        chk_corr(-24'sd40000);
        bus(afcm_pkg::ADDR_CTRL, 1'b1, 32'h0);
        for (int i = 1; i < 4; i++)
        begin
            model.press(1'b1);
            chk({30'h0, eff_mode}, 32'(i % 3));
        end
        model.press(1'b0);
        chk({30'h0, eff_mode}, 32'h0);
        end_sim;
    end
endmodule

`default_nettype wire
